/* bojx_pkg.sv */
package bojx_pkg;
    // prefix and opcode bytes
    localparam logic [7:0] BOJX_PFX_BIT   = 8'hCB;
    localparam logic [7:0] BOJX_PFX_IDX1  = 8'hDD;
    localparam logic [7:0] BOJX_PFX_IDX2  = 8'hFD;
    localparam logic [7:0] BOJX_OP_ABS    = 8'hC3;
    localparam logic [7:0] BOJX_OP_REL    = 8'h18;
    localparam logic [7:0] BOJX_OP_RELC   = 8'h38;
    // absolute conditional jump: 11 ccc 010
    localparam logic [1:0] BOJX_ABSC_HI   = 2'h3;
    localparam logic [2:0] BOJX_ABSC_LO   = 3'h2;
    // bit operation groups in the second byte, bits 7:6
    localparam logic [1:0] BOJX_GRP_CLR   = 2'h2;
    localparam logic [1:0] BOJX_GRP_SET   = 2'h3;
    // register code for a memory operand
    localparam logic [2:0] BOJX_REG_MEM   = 3'h6;
    // flag register bit positions
    localparam int BOJX_FLAG_C  = 0;
    localparam int BOJX_FLAG_PV = 2;
    localparam int BOJX_FLAG_Z  = 6;
    localparam int BOJX_FLAG_S  = 7;
    // clock states per machine cycle
    localparam logic [2:0] BOJX_T_FETCH   = 3'h4;
    localparam logic [2:0] BOJX_T_READ    = 3'h3;
    localparam logic [2:0] BOJX_T_ADD     = 3'h5;
    localparam logic [2:0] BOJX_T_INT     = 3'h4;
    // reset values
    localparam logic [15:0] BOJX_PC_RST   = 16'h0000;
    localparam logic [7:0]  BOJX_FLAG_RST = 8'h00;
    // sequencer states
    typedef enum logic [3:0] {
        BOJX_FETCH  = 4'h0,
        BOJX_PFX2   = 4'h1,
        BOJX_DISP   = 4'h3,
        BOJX_OP2    = 4'h2,
        BOJX_ADDC   = 4'h6,
        BOJX_MRD    = 4'h7,
        BOJX_MWR    = 4'h5,
        BOJX_OPLO   = 4'h4,
        BOJX_OPHI   = 4'hC,
        BOJX_RELD   = 4'hD,
        BOJX_RELADD = 4'hF,
        BOJX_REGOP  = 4'hE,
        BOJX_TRAP   = 4'hA
    } bojx_state_e;
endpackage

/* bojx_exec.sv */
// Function
// - indexed second pair bit-set, 23 states
// - bit-clear targets register, pointer, indexed memory
// - register clear: CB, 10 bbb rrr
// - indexed clear DD/FD CB d 10bbb110
// - clear leaves flags, 8/15/23 states
// - absolute jump loads operand, 10 states
// - first operand byte low, second high
// - conditional absolute jump else sequential
// - condition field selects flag and sense
// - conditional absolute 10 states, flags kept
// - relative jump adds displacement, 12 states
// - relative target from opcode, PC plus two
// - carry relative: taken 12, else 7
`timescale 1ns/100ps
`default_nettype none
module bojx_exec
    import bojx_pkg::*;
(
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    // memory port, at most one access per machine cycle (none while BOJX_RELADD adds)
    output logic      [15:0] memAddr,
    output logic             memRead,
    output logic             memWrite,
    output logic      [7:0]  memWdata,
    input  wire logic [7:0]  memRdata,
    // register file view
    input  wire logic [15:0] pointerPair,
    input  wire logic [15:0] firstIndexPair,
    input  wire logic [15:0] secondIndexPair,
    input  wire logic [7:0]  flagReg,
    input  wire logic [63:0] regBank,
    output logic             regWrite,
    output logic      [2:0]  regSel,
    output logic      [7:0]  regWdata,
    // status
    output logic      [15:0] progCounter,
    output logic             instrDone,
    output logic             illegalOp
);
    // condition test against the flag register
    function automatic logic condHolds(input logic [2:0] cc,
                                       input logic [7:0] f);
        logic bitv;
        bitv = 1'b0;
        case (cc[2:1])
            2'h0:    bitv = f[BOJX_FLAG_Z];
            2'h1:    bitv = f[BOJX_FLAG_C];
            2'h2:    bitv = f[BOJX_FLAG_PV];
            default: bitv = f[BOJX_FLAG_S];
        endcase
        return bitv == cc[0];
    endfunction

    // sign extend and add, modulo 65536
    function automatic logic [15:0] addDisp(input logic [15:0] base,
                                            input logic [7:0]  d);
        return base + {{8{d[7]}}, d};
    endfunction

    bojx_state_e       state, next_state;  // machine cycle
    logic [2:0]        tcnt, next_tcnt;     // clock state within cycle
    logic [2:0]        tlen;                // length of current cycle
    logic [15:0]       pc, next_pc;
    logic [15:0]       ea, next_ea;         // effective address
    logic [7:0]        opc, next_opc;       // first opcode byte
    logic [7:0]        op2, next_op2;       // bit operation byte
    logic [7:0]        lo, next_lo;         // low operand byte
    logic [7:0]        mdat, next_mdat;     // memory operand
    logic              idx, next_idx;       // indexed form
    logic              sel2, next_sel2;     // second index pair
    logic [15:0]       nAddr;
    logic              nRd, nWr, nRegWr, nDone, nIll;
    logic [7:0]        nWdata, nRegWdata, regVal, modVal;
    logic [7:0]        opSel;               // bit operation byte in use
    logic              endCyc;

    // clock states per machine cycle
    always_comb begin
        case (state)
            BOJX_FETCH, BOJX_OP2, BOJX_PFX2: tlen = BOJX_T_FETCH;
            BOJX_ADDC, BOJX_RELADD:          tlen = BOJX_T_ADD;
            BOJX_REGOP:                      tlen = BOJX_T_FETCH;
            BOJX_MRD:  tlen = idx ? BOJX_T_INT : BOJX_T_FETCH;
            default:                         tlen = BOJX_T_READ;
        endcase
    end
    assign endCyc = (tcnt == tlen - 3'h1);

    // byte on the bus while BOJX_OP2 fetches it, the stored byte otherwise (also during BOJX_ADDC)
    assign opSel  = (state == BOJX_OP2) ? memRdata : op2;
    // register operand and the bit modified value
    assign regVal = regBank[opSel[2:0]*8 +: 8];
    always_comb begin
        modVal = (opSel[2:0] == BOJX_REG_MEM) ? mdat : regVal;
        if (opSel[7:6] == BOJX_GRP_SET)
            modVal[opSel[5:3]] = 1'b1;
        else
            modVal[opSel[5:3]] = 1'b0;
    end

    // next state of the sequencer
    always_comb begin
        next_state = state;
        next_tcnt  = endCyc ? 3'h0 : tcnt + 3'h1;
        next_pc    = pc;
        next_ea    = ea;
        next_opc   = opc;
        next_op2   = op2;
        next_lo    = lo;
        next_mdat  = mdat;
        next_idx   = idx;
        next_sel2  = sel2;
        nAddr      = pc;
        nRd        = 1'b0;
        nWr        = 1'b0;
        nWdata     = 8'h00;
        nRegWr     = 1'b0;
        nRegWdata  = 8'h00;
        nDone      = 1'b0;
        nIll       = 1'b0;
        case (state)
            // opcode fetch and first decode
            BOJX_FETCH: begin
                nRd = 1'b1;
                if (endCyc) begin
                    next_pc  = pc + 16'h0001;
                    next_opc = memRdata;
                    next_idx = 1'b0;
                    if (memRdata == BOJX_PFX_BIT) begin
                        next_state = BOJX_OP2;
                    end else if (memRdata == BOJX_PFX_IDX1 ||
                                 memRdata == BOJX_PFX_IDX2) begin
                        next_sel2  = (memRdata == BOJX_PFX_IDX2);
                        next_idx   = 1'b1;
                        next_state = BOJX_PFX2;
                    end else if (memRdata == BOJX_OP_ABS ||
                                 (memRdata[7:6] == BOJX_ABSC_HI &&
                                  memRdata[2:0] == BOJX_ABSC_LO)) begin
                        next_state = BOJX_OPLO;
                    end else if (memRdata == BOJX_OP_REL ||
                                 memRdata == BOJX_OP_RELC) begin
                        next_state = BOJX_RELD;
                    end else begin
                        next_state = BOJX_TRAP;
                    end
                end
            end
            // bit prefix after the index prefix
            BOJX_PFX2: begin
                nRd = 1'b1;
                if (endCyc) begin
                    next_pc    = pc + 16'h0001;
                    next_state = (memRdata == BOJX_PFX_BIT) ?
                                 BOJX_DISP : BOJX_TRAP;
                end
            end
            // displacement byte of an indexed form
            BOJX_DISP: begin
                nRd = 1'b1;
                if (endCyc) begin
                    next_pc    = pc + 16'h0001;
                    next_ea    = addDisp(sel2 ? secondIndexPair :
                                         firstIndexPair, memRdata);
                    next_state = BOJX_ADDC;
                end
            end
            // bit operation byte; indexed forms read it during the
            // five state address add cycle, which keeps them at 23
            BOJX_ADDC, BOJX_OP2: begin
                nRd = 1'b1;
                if (endCyc) begin
                    next_pc  = pc + 16'h0001;
                    next_op2 = memRdata;
                    if (!(memRdata[7:6] == BOJX_GRP_CLR ||
                          (idx && memRdata[7:6] == BOJX_GRP_SET)) ||
                        (idx && memRdata[2:0] != BOJX_REG_MEM))
                        next_state = BOJX_TRAP;
                    else if (memRdata[2:0] == BOJX_REG_MEM) begin
                        if (!idx)
                            next_ea = pointerPair;
                        next_state = BOJX_MRD;
                    end else begin
                        // register form ends with this fetch: 8 states
                        nDone      = 1'b1;
                        nRegWr     = 1'b1;
                        nRegWdata  = modVal;
                        next_state = BOJX_FETCH;
                    end
                end
            end
            // operand read, 4 states
            BOJX_MRD: begin
                nAddr = ea;
                nRd   = 1'b1;
                if (endCyc) begin
                    next_mdat  = memRdata;
                    next_state = BOJX_MWR;
                end
            end
            // modified operand write, flags untouched
            BOJX_MWR: begin
                nAddr  = ea;
                nWr    = 1'b1;
                nWdata = modVal;
                if (endCyc) begin
                    nDone      = 1'b1;
                    next_state = BOJX_FETCH;
                end
            end
            // low operand byte
            BOJX_OPLO: begin
                nRd = 1'b1;
                if (endCyc) begin
                    next_pc    = pc + 16'h0001;
                    next_lo    = memRdata;
                    next_state = BOJX_OPHI;
                end
            end
            // high operand byte and jump decision
            BOJX_OPHI: begin
                nRd = 1'b1;
                if (endCyc) begin
                    nDone      = 1'b1;
                    next_state = BOJX_FETCH;
                    if (opc == BOJX_OP_ABS ||
                        condHolds(opc[5:3], flagReg))
                        next_pc = {memRdata, lo};
                    else
                        next_pc = pc + 16'h0001;
                end
            end
            // relative displacement read
            BOJX_RELD: begin
                nRd = 1'b1;
                if (endCyc) begin
                    next_pc = pc + 16'h0001;
                    next_lo = memRdata;
                    if (opc == BOJX_OP_RELC && !flagReg[BOJX_FLAG_C]) begin
                        nDone      = 1'b1;
                        next_state = BOJX_FETCH;
                    end else
                        next_state = BOJX_RELADD;
                end
            end
            // add displacement to twice advanced counter
            BOJX_RELADD: begin
                if (endCyc) begin
                    nDone      = 1'b1;
                    next_pc    = addDisp(pc, lo);
                    next_state = BOJX_FETCH;
                end
            end
            // unsupported opcode: flag it and go on
            BOJX_TRAP: begin
                nIll       = 1'b1;
                nDone      = 1'b1;
                next_state = BOJX_FETCH;
                next_tcnt  = 3'h0;
            end
            default: begin
                next_state = BOJX_FETCH;
                next_tcnt  = 3'h0;
            end
        endcase
    end

    // registers of the sequencer and outputs
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            state       <= BOJX_FETCH;
            tcnt        <= 3'h0;
            pc          <= BOJX_PC_RST;
            ea          <= 16'h0000;
            opc         <= 8'h00;
            op2         <= 8'h00;
            lo          <= 8'h00;
            mdat        <= 8'h00;
            idx         <= 1'b0;
            sel2        <= 1'b0;
            memAddr     <= BOJX_PC_RST;
            memRead     <= 1'b0;
            memWrite    <= 1'b0;
            memWdata    <= 8'h00;
            regWrite    <= 1'b0;
            regSel      <= 3'h0;
            regWdata    <= 8'h00;
            progCounter <= BOJX_PC_RST;
            instrDone   <= 1'b0;
            illegalOp   <= 1'b0;
        end else begin
            state       <= next_state;
            tcnt        <= next_tcnt;
            pc          <= next_pc;
            ea          <= next_ea;
            opc         <= next_opc;
            op2         <= next_op2;
            lo          <= next_lo;
            mdat        <= next_mdat;
            idx         <= next_idx;
            sel2        <= next_sel2;
            memAddr     <= nAddr;
            memRead     <= nRd;
            memWrite    <= nWr;
            memWdata    <= nWdata;
            regWrite    <= nRegWr;
            regSel      <= next_op2[2:0];
            regWdata    <= nRegWdata;
            progCounter <= next_pc;
            instrDone   <= nDone;
            illegalOp   <= nIll;
        end
    end
endmodule // bojx_exec
`default_nettype wire

/* bojx_exec_properties.sv */
`timescale 1ns/100ps
`default_nettype none
module bojx_exec_chk
    import bojx_pkg::*;
(
    // clock and reset
    input wire logic        ref_clk,
    input wire logic        sys_rst,
    // memory port
    input wire logic [15:0] memAddr,
    input wire logic        memRead,
    input wire logic        memWrite,
    input wire logic [7:0]  memWdata,
    // register view
    input wire logic [63:0] regBank,
    input wire logic        regWrite,
    input wire logic [2:0]  regSel,
    input wire logic [7:0]  regWdata,
    // status
    input wire logic [15:0] progCounter,
    input wire logic        instrDone,
    input wire logic        illegalOp
);
    logic [7:0] oldByte;  // register content before the write
    assign oldByte = regBank[regSel*8 +: 8];
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    // a write machine cycle: three states, then released
    sequence wr_cycle_s;
        memWrite [*3] ##1 !memWrite;
    endsequence
    wr_len_a: assert property ($rose(memWrite) |-> wr_cycle_s)
        else $error("write cycle length wrong");
    wr_after_rd_a: assert property ($rose(memWrite) |-> $past(memRead))
        else $error("write not preceded by read");
    wr_stable_a: assert property (memWrite && $past(memWrite) |->
        $stable(memAddr) && $stable(memWdata))
        else $error("write address or data moved");
    bus_excl_a: assert property (!(memWrite && (memRead || regWrite)))
        else $error("write overlaps another access");
    reg_one_bit_a: assert property (regWrite |-> regSel != BOJX_REG_MEM &&
        (regWdata & ~oldByte) == 8'h00 &&
        $countones(regWdata ^ oldByte) <= 1)
        else $error("register write changed more than one bit");
    reg_pulse_a: assert property (regWrite |=> !regWrite)
        else $error("register write longer than one cycle");
    done_gap_a: assert property (instrDone |=> !instrDone [*3])
        else $error("completions too close");
    ill_pulse_a: assert property (illegalOp |=> !illegalOp)
        else $error("illegal flag longer than one cycle");
    rst_idle_a: assert property (disable iff (1'b0) $fell(sys_rst) |->
        progCounter == BOJX_PC_RST && !memWrite && !instrDone)
        else $error("not idle after reset");
endmodule // bojx_exec_chk
bind bojx_exec bojx_exec_chk chk_u (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .memAddr(memAddr),
    .memRead(memRead), .memWrite(memWrite), .memWdata(memWdata),
    .regBank(regBank), .regWrite(regWrite), .regSel(regSel),
    .regWdata(regWdata), .progCounter(progCounter),
    .instrDone(instrDone), .illegalOp(illegalOp)
);
`default_nettype wire

/* bojx_mem_model.sv */
`timescale 1ns/100ps
`default_nettype none
module bojx_mem_model (
    // clock
    input wire logic        ref_clk,
    // memory port
    input wire logic [15:0] memAddr,
    input wire logic        memRead,
    input wire logic        memWrite,
    input wire logic [7:0]  memWdata,
    output logic     [7:0]  memRdata
);
    logic [7:0] mem [0:65535];  // whole space, addresses wrap
    logic [7:0] lastData;       // byte last handed out
    // zero latency read; an idle bus shows inverted junk, not old data
    always_comb begin
        memRdata = memRead ? mem[memAddr] : ~lastData;
    end
    // remember the last byte read and commit writes
    always @(posedge ref_clk) begin
        if (memRead) begin
            lastData <= mem[memAddr];
        end
        if (memWrite) begin
            mem[memAddr] <= memWdata;
        end
    end
endmodule // bojx_mem_model
`default_nettype wire

/* tb.sv */
`timescale 1ns/100ps
`default_nettype none
module tb;
    import bojx_pkg::*;
    // one row: code bytes, flags, expected clock states
    typedef struct packed {
        logic [7:0] b0, b1, b2, b3, flg;
        logic [4:0] t;
    } bojx_row_s;
    localparam int NR = 28;
    logic ref_clk = 1'b0, sys_rst = 1'b1;    // clock, reset
    logic [15:0] memAddr, progCounter;       // design outputs
    logic memRead, memWrite, regWrite, instrDone, illegalOp;
    logic [7:0] memWdata, memRdata, regWdata, flagReg;
    logic [2:0] regSel;
    logic [15:0] pointerPair, firstIndexPair, secondIndexPair;
    logic [63:0] regBank;
    bojx_row_s rows [NR];                    // test table
    logic [15:0] expPc [NR], expAdr [NR];    // expected pc, place
    logic [7:0] expV [NR];                   // expected byte
    logic isMem [NR];                        // memory form
    int n_mismatch = 0, n_tests = 0;
    bojx_exec dut_u (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .memAddr(memAddr), .memRead(memRead), .memWrite(memWrite),
        .memWdata(memWdata), .memRdata(memRdata),
        .pointerPair(pointerPair), .firstIndexPair(firstIndexPair),
        .secondIndexPair(secondIndexPair), .flagReg(flagReg),
        .regBank(regBank), .regWrite(regWrite), .regSel(regSel),
        .regWdata(regWdata), .progCounter(progCounter),
        .instrDone(instrDone), .illegalOp(illegalOp));
    bojx_mem_model mm_u (.ref_clk(ref_clk), .memAddr(memAddr),
        .memRead(memRead), .memWrite(memWrite), .memWdata(memWdata),
        .memRdata(memRdata));
    always #5 ref_clk = ~ref_clk;
    // compare one result
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // print counts and verdict
    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // condition field against flags
    function automatic logic taken(input logic [2:0] c, input logic [7:0] f);
        logic v;
        case (c[2:1])
            2'h0: v = f[BOJX_FLAG_Z];
            2'h1: v = f[BOJX_FLAG_C];
            2'h2: v = f[BOJX_FLAG_PV];
            default: v = f[BOJX_FLAG_S];
        endcase
        return c[0] ? v : !v;
    endfunction
    // states until the next completion, bounded; outputs are looked at
    // on the falling edge, where they have settled
    task automatic wait_done(output int n);
        n = 0;
        do begin
            @(negedge ref_clk);
            n++;
        end while (instrDone !== 1'b1 && n < 40);
    endtask
    // watchdog
    initial begin
        repeat (2000) @(posedge ref_clk);
        n_mismatch++;
        complete_run();
    end
    initial begin
        int i, n;
        logic [15:0] pc, nxt;
        logic [7:0] ob, m;
        bojx_row_s r;
        pointerPair = 16'h3000;
        firstIndexPair = 16'h0010;
        secondIndexPair = 16'h2000;
        regBank = 64'hFFEEDDCCBBAA9988;
        rows[0] = {8'hC3, 8'h00, 8'h08, 8'h00, 8'h41, 5'd10};
        rows[1] = {8'h18, 8'h7F, 16'h0, 8'h41, 5'd12};
        rows[2] = {8'h18, 8'h80, 16'h0, 8'h41, 5'd12};
        for (i = 0; i < 16; i++) begin
            rows[3+i] = {8'hC2 | {2'h0, i[2:0], 3'h0}, 24'h0,
                i[3] ? 8'hBE : 8'h41, 5'd10};
        end
        rows[19] = {8'h38, 8'h40, 16'h0, 8'h41, 5'd12};
        rows[20] = {8'h38, 8'h40, 16'h0, 8'hBE, 5'd7};
        rows[21] = {8'hCB, 8'hA2, 16'h0, 8'h41, 5'd8};
        rows[22] = {8'hCB, 8'hBF, 16'h0, 8'h41, 5'd8};
        rows[23] = {8'hCB, 8'h8E, 16'h0, 8'h41, 5'd15};
        rows[24] = {8'hDD, 8'hCB, 8'h80, 8'hB6, 8'h41, 5'd23};
        rows[25] = {8'hFD, 8'hCB, 8'hFF, 8'hC6, 8'h41, 5'd23};
        rows[26] = {8'hFD, 8'hCB, 8'h05, 8'hFE, 8'h41, 5'd23};
        rows[27] = {8'hFD, 8'hCB, 8'h02, 8'h8E, 8'h41, 5'd23};
        // lay the program out along the expected path
        pc = 16'h0000;
        for (i = 0; i < NR; i++) begin
            r = rows[i];
            nxt = pc + 16'h0003;
            if (r.b0[7:6] == BOJX_ABSC_HI && r.b0[2:0] == BOJX_ABSC_LO) begin
                {r.b2, r.b1} = pc + 16'h0005;
                if (taken(r.b0[5:3], r.flg)) nxt = {r.b2, r.b1};
            end
            if (r.b0 == BOJX_OP_ABS) nxt = {r.b2, r.b1};
            if (r.b0 == BOJX_OP_REL || r.b0 == BOJX_OP_RELC) begin
                nxt = pc + 16'h0002;
                if (r.b0 == BOJX_OP_REL || r.flg[BOJX_FLAG_C])
                    nxt = nxt + {{8{r.b1[7]}}, r.b1};
            end
            isMem[i] = 1'b0;
            if (r.b0 == BOJX_PFX_BIT) begin
                nxt = pc + 16'h0002;
                expAdr[i] = pointerPair;
                ob = r.b1;
            end else begin
                nxt = (r.b0[3:0] == 4'hD) ? pc + 16'h0004 : nxt;
                expAdr[i] = (r.b0 == BOJX_PFX_IDX1 ? firstIndexPair
                    : secondIndexPair) + {{8{r.b2[7]}}, r.b2};
                ob = r.b3;
            end
            m = 8'h01 << ob[5:3];
            if (ob[2:0] == BOJX_REG_MEM) begin
                isMem[i] = 1'b1;
                mm_u.mem[expAdr[i]] = 8'h5A;
                expV[i] = (ob[7:6] == BOJX_GRP_SET) ? 8'h5A | m : 8'h5A & ~m;
            end else begin
                expAdr[i] = {13'h0, ob[2:0]};
                expV[i] = regBank[ob[2:0]*8 +: 8] & ~m;
            end
            mm_u.mem[pc] = r.b0;
            mm_u.mem[pc+16'h1] = r.b1;
            mm_u.mem[pc+16'h2] = r.b2;
            mm_u.mem[pc+16'h3] = r.b3;
            rows[i] = r;
            expPc[i] = nxt;
            pc = nxt;
        end
        mm_u.mem[pc] = 8'h00;
        flagReg = rows[0].flg;
        repeat (11) @(posedge ref_clk);
        chk(progCounter, BOJX_PC_RST);
        @(posedge ref_clk);
        sys_rst <= 1'b0;
        for (i = 0; i < NR; i++) begin
            flagReg <= rows[i].flg;
            wait_done(n);
            if (i > 0) chk(n[15:0], {11'h0, rows[i].t});
            chk(progCounter, expPc[i]);
            if (rows[i].b0 inside {BOJX_PFX_BIT, BOJX_PFX_IDX1, BOJX_PFX_IDX2})
            begin
                if (isMem[i]) chk({8'h0, mm_u.mem[expAdr[i]]}, {8'h0, expV[i]});
                else chk({4'h0, regWrite, regSel, regWdata},
                    {4'h0, 1'b1, expAdr[i][2:0], expV[i]});
            end
            @(posedge ref_clk);
        end
        n = 0;
        while (illegalOp !== 1'b1 && n < 12) begin
            @(negedge ref_clk);
            n++;
        end
        chk({15'h0, illegalOp}, 16'h0001);
        complete_run();
    end
endmodule // tb
`default_nettype wire
